// ===== core/rxdc_pkg.sv
// Purpose: Shared constants, types and state codes of the receiver duty, level meter and keying control
// Assumes: The digital clock period equals one CLK period (100 MHz)
// Notes:   Timing figures are kept in their own unit and converted to cycles here
package rxdc_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned DIGCLK_PERIOD_NS = 10;
  localparam int unsigned DIGCLK_CYCLES    = DIGCLK_PERIOD_NS / CLK_PERIOD_NS;

  // On time unit and level meter sequencing, in digital clock periods
  localparam int unsigned ON_UNIT_PERIODS  = 512;
  localparam int unsigned CLEAR_PERIODS    = 7;
  localparam int unsigned CONV_PERIODS     = 16;
  localparam int unsigned UPDATE_PERIODS   = 32;

  localparam logic [3:0]  CLEAR_LAST       = 4'(CLEAR_PERIODS * DIGCLK_CYCLES - 1);
  localparam logic [4:0]  CONV_LAST        = 5'(CONV_PERIODS * DIGCLK_CYCLES - 1);
  localparam logic [4:0]  UPDATE_LAST      = 5'(UPDATE_PERIODS * DIGCLK_CYCLES - 1);
  localparam logic [12:0] ON_UNIT_CYCLES   = 13'(ON_UNIT_PERIODS * DIGCLK_CYCLES);

  // Receiver settling (oscillator wakeup, lock, analog), least time, rounded up
  localparam int unsigned SETTLE_TIME_NS   = 1000;
  localparam logic [11:0] SETTLE_CYCLES    = 12'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Default strobe period in CLK cycles; the real figure depends on the external capacitor
  localparam int unsigned WAKE_OSC_DEFAULT = 1000;

  localparam logic [7:0]  STATUS_RESET     = 8'h00;

  typedef struct packed {
    logic       tx_mode;
    logic       strobe_osc_enable;
    logic [3:0] on_time_field;
    logic [2:0] off_time_field;
    logic       level_meter_enable;
    logic       level_sample_mode;
    logic       keying_select;
    logic       low_voltage_detect_enable;
  } rxdc_cfg_t;

  // Gray codes along config -> off -> on -> hold
  typedef enum logic [2:0] {
    ST_CONFIG  = 3'h0,
    ST_RX_OFF  = 3'h1,
    ST_RX_ON   = 3'h3,
    ST_RX_HOLD = 3'h2,
    ST_TX      = 3'h6,
    ST_STANDBY = 3'h7
  } rxdc_state_t;

  typedef enum logic [2:0] {
    RS_DOWN  = 3'h0,
    RS_CLEAR = 3'h1,
    RS_READY = 3'h3,
    RS_TRACK = 3'h2,
    RS_HOLD  = 3'h6
  } rxdc_lvl_t;

endpackage

// ===== core/rxdc_ctrl.sv
// Purpose: Mode control: receiver duty cycling, level meter sequencing, raw transmit keying, standby
// Assumes: CLK is the crystal-derived digital clock; pin inputs are asynchronous
// Notes:   The strobe oscillator is modelled as a CLK-based period counter that the low pin halts
`timescale 1ns/1ps

module rxdc_ctrl
  import rxdc_pkg::*;
#(
  parameter int unsigned WAKE_OSC_CYCLES = WAKE_OSC_DEFAULT
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire rxdc_cfg_t  CFG,
  input  wire logic       CONFIG_SELECT_N,
  input  wire logic       STROBE_HIGH,
  input  wire logic       STROBE_LOW,
  input  wire logic       LEVEL_CAPTURE_INPUT,
  input  wire logic       SERIAL_DATA_IN,
  input  wire logic       PLL_LOCKED,
  input  wire logic       XTAL_STARTED,
  input  wire logic       ID_MATCH,
  input  wire logic       FRAME_DONE,
  input  wire logic [3:0] LEVEL_ADC_CODE,
  output logic            RX_ON,
  output logic            RX_DATA_VALID,
  output logic            STROBE_DISCHARGE_EN,
  output logic            PA_ENABLE,
  output logic            CARRIER_SELECT,
  output logic            PEAK_CLEAR_SWITCH,
  output logic            TRACK_HOLD_SWITCH,
  output logic            ADC_SELECT_LNA,
  output logic            LEVEL_METER_POWER,
  output logic            LEVEL_ANALOG_OUT_OE,
  output logic [7:0]      SIGNAL_STRENGTH_STATUS,
  output logic            STANDBY,
  output logic            LVD_ENABLE
);

  localparam logic [15:0] WAKE_PER  = 16'(WAKE_OSC_CYCLES);
  localparam logic [15:0] WAKE_HALF = 16'(WAKE_OSC_CYCLES / 2);

  // Off period count N from the 3-bit field
  function automatic logic [3:0] off_periods(input logic [2:0] f);
    off_periods = {1'b0, f} + 4'h1;
  endfunction

  // Two-stage synchronisers for all pin inputs
  logic [1:0] meta_q [6];
  logic [5:0] pins;
  logic       config_s, strobe_hi_s, strobe_lo_s, capture_s, data_s, pll_s;
  assign pins = {CONFIG_SELECT_N, STROBE_HIGH, STROBE_LOW, LEVEL_CAPTURE_INPUT, SERIAL_DATA_IN, PLL_LOCKED};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          meta_q[gi] <= 2'b00;
        end else if (CE) begin
          meta_q[gi] <= {meta_q[gi][0], pins[gi]};
        end
      end
    end
  endgenerate

  assign {config_s, strobe_hi_s, strobe_lo_s, capture_s, data_s, pll_s} =
    {meta_q[5][1], meta_q[4][1], meta_q[3][1], meta_q[2][1], meta_q[1][1], meta_q[0][1]};

  // Mode and duty cycling
  rxdc_state_t state_q, state_d;
  logic [12:0] on_cnt_q, on_cnt_d;
  logic [15:0] per_cnt_q, per_cnt_d;
  logic [3:0]  off_n_q, off_n_d;
  logic        off_tail_q, off_tail_d;
  logic        id_seen_q, id_seen_d;
  logic [11:0] settle_q, settle_d;
  logic [12:0] on_limit;
  logic [15:0] tail_len;
  logic        rx_on_st, settled;

  assign on_limit = 13'(CFG.on_time_field * ON_UNIT_CYCLES);
  assign tail_len = ({3'h0, on_limit} < WAKE_HALF) ? {3'h0, on_limit} : WAKE_HALF;
  assign rx_on_st = (state_q == ST_RX_ON) || (state_q == ST_RX_HOLD);
  assign settled  = (settle_q == SETTLE_CYCLES);

  always_comb begin
    state_d    = state_q;
    on_cnt_d   = on_cnt_q;
    per_cnt_d  = per_cnt_q;
    off_n_d    = off_n_q;
    off_tail_d = off_tail_q;
    id_seen_d  = id_seen_q;
    settle_d   = settle_q;
    if (rx_on_st && XTAL_STARTED && !settled) begin
      settle_d = settle_q + 12'h001;
    end
    if (state_q == ST_RX_ON && settled && ID_MATCH) begin
      id_seen_d = 1'b1;
    end
    unique case (state_q)
      ST_CONFIG: begin
        if (config_s) begin
          if (!strobe_hi_s) begin
            state_d = ST_STANDBY;
          end else if (CFG.tx_mode) begin
            state_d = ST_TX;
          end else begin
            state_d = ST_RX_ON;
          end
        end
      end
      ST_STANDBY: begin
        // Only way out is back to configuration
        if (!config_s && strobe_hi_s) begin
          state_d = ST_CONFIG;
        end
      end
      ST_TX: begin
        if (!config_s) begin
          state_d = ST_CONFIG;
        end
      end
      ST_RX_OFF: begin
        if (!config_s) begin
          state_d = ST_CONFIG;
        end else if (strobe_hi_s) begin
          state_d = ST_RX_ON;
        end else if (CFG.strobe_osc_enable && !strobe_lo_s) begin
          // Strobe clock runs only while the pin is not held low
          if (per_cnt_q + 16'h0001 >= (off_tail_q ? tail_len : WAKE_PER)) begin
            per_cnt_d = 16'h0000;
            if (off_tail_q) begin
              state_d = ST_RX_ON;
            end else if (off_n_q + 4'h1 >= off_periods(CFG.off_time_field)) begin
              off_tail_d = 1'b1;
            end else begin
              off_n_d = off_n_q + 4'h1;
            end
          end else begin
            per_cnt_d = per_cnt_q + 16'h0001;
          end
        end
      end
      ST_RX_ON: begin
        if (!config_s) begin
          state_d = ST_CONFIG;
        end else if (strobe_lo_s && !strobe_hi_s) begin
          state_d = ST_RX_OFF;
        end else if (!CFG.strobe_osc_enable) begin
          if (!strobe_hi_s) begin
            state_d = ST_RX_OFF;
          end
        end else if (!strobe_hi_s && XTAL_STARTED) begin
          if (on_cnt_q + 13'h0001 >= on_limit) begin
            state_d = id_seen_d ? ST_RX_HOLD : ST_RX_OFF;
          end else begin
            on_cnt_d = on_cnt_q + 13'h0001;
          end
        end
      end
      ST_RX_HOLD: begin
        if (!config_s) begin
          state_d = ST_CONFIG;
        end else if ((strobe_lo_s && !strobe_hi_s) || FRAME_DONE) begin
          state_d = ST_RX_OFF;
        end
      end
      default: begin
        state_d = ST_CONFIG;
      end
    endcase
    if (state_d != state_q) begin
      on_cnt_d   = 13'h0000;
      per_cnt_d  = 16'h0000;
      off_n_d    = 4'h0;
      off_tail_d = 1'b0;
      if (state_d == ST_RX_ON) begin
        id_seen_d = 1'b0;
      end
      if (!(rx_on_st && state_d == ST_RX_HOLD)) begin
        settle_d = 12'h000;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q    <= ST_STANDBY;
      on_cnt_q   <= 13'h0000;
      per_cnt_q  <= 16'h0000;
      off_n_q    <= 4'h0;
      off_tail_q <= 1'b0;
      id_seen_q  <= 1'b0;
      settle_q   <= 12'h000;
    end else if (CE) begin
      state_q    <= state_d;
      on_cnt_q   <= on_cnt_d;
      per_cnt_q  <= per_cnt_d;
      off_n_q    <= off_n_d;
      off_tail_q <= off_tail_d;
      id_seen_q  <= id_seen_d;
      settle_q   <= settle_d;
    end
  end

  // Level meter sequencer and shared converter
  rxdc_lvl_t  lvl_q, lvl_d;
  logic [3:0] clr_q, clr_d;
  logic [4:0] conv_q, conv_d;
  logic [7:0] status_q, status_d;
  logic       cap_prev_q, cap_prev_d;
  logic       meter_on, converting;

  assign meter_on   = CFG.level_meter_enable && rx_on_st;
  assign converting = (lvl_q != RS_DOWN) && (lvl_q != RS_HOLD);

  always_comb begin
    lvl_d      = lvl_q;
    clr_d      = clr_q;
    conv_d     = conv_q;
    status_d   = status_q;
    cap_prev_d = capture_s;
    if (converting) begin
      conv_d = (conv_q == UPDATE_LAST) ? 5'h00 : conv_q + 5'h01;
      if (conv_q == CONV_LAST) begin
        status_d[3:0] = LEVEL_ADC_CODE;
      end else if (conv_q == UPDATE_LAST) begin
        status_d[7:4] = LEVEL_ADC_CODE;
      end
    end
    unique case (lvl_q)
      RS_DOWN: begin
        if (meter_on) begin
          lvl_d = RS_CLEAR;
          clr_d = 4'h0;
          conv_d = 5'h00;
        end
      end
      RS_CLEAR: begin
        clr_d = clr_q + 4'h1;
        if (clr_q == CLEAR_LAST) begin
          lvl_d = RS_READY;
        end
      end
      RS_READY: begin
        if (capture_s) begin
          lvl_d = RS_TRACK;
        end
      end
      RS_TRACK: begin
        if (!capture_s) begin
          lvl_d = CFG.level_sample_mode ? RS_HOLD : RS_READY;
        end
      end
      RS_HOLD: begin
        // A new capture pulse starts a fresh peak measurement
        if (capture_s && !cap_prev_q) begin
          lvl_d = RS_CLEAR;
          clr_d = 4'h0;
        end
      end
      default: begin
        lvl_d = RS_DOWN;
      end
    endcase
    if (!meter_on) begin
      lvl_d = RS_DOWN;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lvl_q      <= RS_DOWN;
      clr_q      <= 4'h0;
      conv_q     <= 5'h00;
      status_q   <= STATUS_RESET;
      cap_prev_q <= 1'b0;
    end else if (CE) begin
      lvl_q      <= lvl_d;
      clr_q      <= clr_d;
      conv_q     <= conv_d;
      status_q   <= status_d;
      cap_prev_q <= cap_prev_d;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_ON                  <= 1'b0;
      RX_DATA_VALID          <= 1'b0;
      STROBE_DISCHARGE_EN    <= 1'b0;
      PA_ENABLE              <= 1'b0;
      CARRIER_SELECT         <= 1'b0;
      PEAK_CLEAR_SWITCH      <= 1'b0;
      TRACK_HOLD_SWITCH      <= 1'b0;
      ADC_SELECT_LNA         <= 1'b0;
      LEVEL_METER_POWER      <= 1'b0;
      LEVEL_ANALOG_OUT_OE    <= 1'b0;
      SIGNAL_STRENGTH_STATUS <= STATUS_RESET;
      STANDBY                <= 1'b0;
      LVD_ENABLE             <= 1'b0;
    end else if (CE) begin
      RX_ON                  <= (state_d == ST_RX_ON) || (state_d == ST_RX_HOLD);
      RX_DATA_VALID          <= rx_on_st && settled && (state_d == state_q);
      STROBE_DISCHARGE_EN    <= CFG.strobe_osc_enable && !CFG.tx_mode && !strobe_hi_s;
      // Lock loss cuts the stage one cycle after the synchronised lock drops; data is passed raw with no framing
      PA_ENABLE              <= (state_d == ST_TX) && pll_s && (CFG.keying_select || data_s);
      CARRIER_SELECT         <= (state_d == ST_TX) && CFG.keying_select && data_s;
      PEAK_CLEAR_SWITCH      <= (lvl_d == RS_CLEAR);
      TRACK_HOLD_SWITCH      <= (lvl_d == RS_TRACK);
      ADC_SELECT_LNA         <= conv_d[4];
      LEVEL_METER_POWER      <= (lvl_d != RS_DOWN);
      LEVEL_ANALOG_OUT_OE    <= (lvl_d != RS_DOWN);
      SIGNAL_STRENGTH_STATUS <= status_d;
      STANDBY                <= (state_d == ST_STANDBY) && !CFG.low_voltage_detect_enable;
      LVD_ENABLE             <= (state_d == ST_STANDBY) && CFG.low_voltage_detect_enable;
    end
  end

  chk_lock_cut: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && !pll_s |=> !PA_ENABLE) else $error("output stage on without lock");
  chk_ook_key: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_q == ST_TX && config_s && pll_s && !CFG.keying_select |=> PA_ENABLE == $past(data_s))
    else $error("on-off keying does not follow data");
  chk_fsk_carrier: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_q == ST_TX && config_s && CFG.keying_select |=> CARRIER_SELECT == $past(data_s) && PA_ENABLE == $past(pll_s))
    else $error("carrier select does not follow data");
  chk_settle_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    RX_DATA_VALID |-> $past(settled) && RX_ON) else $error("data valid during settling");
  chk_force_on: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && strobe_hi_s && config_s && (state_q == ST_RX_OFF || state_q == ST_RX_ON) |=> RX_ON && !STROBE_DISCHARGE_EN)
    else $error("strobe high did not force receiver on");
  chk_halt_off: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_q == ST_RX_OFF && strobe_lo_s && !strobe_hi_s && config_s |=> state_q == ST_RX_OFF && $stable(per_cnt_q))
    else $error("strobe clock ran while pin held low");
  chk_on_length: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_q == ST_RX_ON && config_s && CFG.strobe_osc_enable && !strobe_hi_s && !strobe_lo_s && XTAL_STARTED
    && on_cnt_q + 13'h0001 < on_limit |=> state_q == ST_RX_ON && on_cnt_q == $past(on_cnt_q) + 13'h0001)
    else $error("on interval ended early");
  chk_clear_len: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && meter_on && lvl_q == RS_CLEAR && clr_q == CLEAR_LAST |=> lvl_q == RS_READY)
    else $error("peak clear length wrong");
  chk_status_low: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && converting && conv_q == CONV_LAST |=> status_q[3:0] == $past(LEVEL_ADC_CODE))
    else $error("low nibble not updated");
  chk_standby_stay: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && state_q == ST_STANDBY && config_s |=> state_q == ST_STANDBY) else $error("standby left without config");

endmodule

// ===== tb/rxdc_host.sv
// Purpose: Host model driving the configuration, strobe, capture and data pins
// Assumes: Pins change 1 ns after the rising clock edge
// Notes:   Strobe level 0 released, 1 driven high, 2 driven low
`timescale 1ns/1ps
module rxdc_host (
  input  wire logic clk,
  output logic      config_select_n,
  output logic      strobe_high,
  output logic      strobe_low,
  output logic      capture,
  output logic      serial_data
);
  initial begin
    config_select_n = 1'b1;
    strobe_high     = 1'b0;
    strobe_low      = 1'b0;
    capture         = 1'b0;
    serial_data     = 1'b0;
  end

  task automatic strobe(input int lvl);
    @(posedge clk);
    #1;
    strobe_high = (lvl == 1);
    strobe_low  = (lvl == 2);
  endtask

  // Passing through low empties the capacitor, else the on state lingers
  task automatic release_strobe();
    strobe(2);
    strobe(0);
  endtask

  // Configuration is reached with select low; from standby the strobe must also be high
  task automatic to_config();
    strobe(1);
    config_select_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Leaving with strobe low parks the device in standby
  task automatic leave_config(input int lvl);
    strobe(lvl);
    config_select_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic drive(input logic cap, input logic dat);
    @(posedge clk);
    #1;
    capture     = cap;
    serial_data = dat;
  endtask
endmodule

// ===== tb/rxdc_ctrl_tb.sv
// Purpose: Self-checking bench for duty cycling, level meter, keying and standby
// Assumes: Short strobe period so off intervals stay brief
// Notes:   Converter codes follow the converter select so nibble order shows
`timescale 1ns/1ps
module rxdc_ctrl_tb;
  import rxdc_pkg::*;
  localparam int WAKE = 8;
  logic       clk = 1'b0;
  logic       rst_n, ce, xtal, pll, id_match, frame_done;
  rxdc_cfg_t  cfg;
  logic [3:0] lo_code, hi_code;
  logic       cfg_n, stb_hi, stb_lo, cap, sdat;
  logic       rx_on, rx_valid, dis_en, pa_en, car_sel, peak_clr, track;
  logic       sel_lna, lvl_pwr, lvl_oe, standby, lvd;
  logic [7:0] status;
  int         num_errors = 0;
  int         total_checks = 0;
  int         n;

  always #5 clk = ~clk;

  rxdc_host host (.clk(clk), .config_select_n(cfg_n), .strobe_high(stb_hi), .strobe_low(stb_lo),
    .capture(cap), .serial_data(sdat));

  rxdc_ctrl #(.WAKE_OSC_CYCLES(WAKE)) uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .CFG(cfg),
    .CONFIG_SELECT_N(cfg_n), .STROBE_HIGH(stb_hi), .STROBE_LOW(stb_lo), .LEVEL_CAPTURE_INPUT(cap),
    .SERIAL_DATA_IN(sdat), .PLL_LOCKED(pll), .XTAL_STARTED(xtal), .ID_MATCH(id_match),
    .FRAME_DONE(frame_done), .LEVEL_ADC_CODE(sel_lna ? hi_code : lo_code), .RX_ON(rx_on),
    .RX_DATA_VALID(rx_valid), .STROBE_DISCHARGE_EN(dis_en), .PA_ENABLE(pa_en),
    .CARRIER_SELECT(car_sel), .PEAK_CLEAR_SWITCH(peak_clr), .TRACK_HOLD_SWITCH(track),
    .ADC_SELECT_LNA(sel_lna), .LEVEL_METER_POWER(lvl_pwr), .LEVEL_ANALOG_OUT_OE(lvl_oe),
    .SIGNAL_STRENGTH_STATUS(status), .STANDBY(standby), .LVD_ENABLE(lvd));

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    check(name, {7'h0, exp}, {7'h0, got});
  endtask

  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic probe(input int sig);
    case (sig)
      0: return rx_on;
      1: return peak_clr;
      default: return sel_lna;
    endcase
  endfunction

  // Counts cycles until the chosen output reaches lvl; a hang ends the run
  task automatic wait_for(input int sig, input logic lvl, output int k);
    k = 0;
    while (probe(sig) !== lvl) begin
      cyc(1);
      k++;
      if (k > 3000) begin
        num_errors++;
        $display("CHECK FAILED wait %0d expected %b seen timeout", sig, lvl);
        summarize();
      end
    end
  endtask

  task automatic t_standby();
    check1("standby", 1'b1, standby);
    host.drive(1'b1, 1'b1);
    cyc(8);
    check1("rx_on", 1'b0, rx_on);
    check1("pa", 1'b0, pa_en);
    check1("standby_kept", 1'b1, standby);
    host.drive(1'b0, 1'b0);
    $display("test standby done");
  endtask

  task automatic t_settle();
    host.to_config();
    check1("standby_left", 1'b0, standby);
    host.leave_config(1);
    check1("pin_on", 1'b1, rx_on);
    check1("disch_high", 1'b0, dis_en);
    xtal = 1'b1;
    cyc(90);
    check1("valid_early", 1'b0, rx_valid);
    // Clock enable low must freeze the settling count as well
    ce = 1'b0;
    cyc(30);
    check1("valid_frozen", 1'b0, rx_valid);
    ce = 1'b1;
    cyc(20);
    check1("valid", 1'b1, rx_valid);
    host.strobe(2);
    cyc(5);
    check1("pin_off", 1'b0, rx_on);
    $display("test settle done");
  endtask

  task automatic t_duty();
    host.to_config();
    cfg.strobe_osc_enable = 1'b1;
    cfg.on_time_field = 4'h1;
    cfg.off_time_field = 3'h0;
    // A released strobe on leaving configuration parks the device in standby, so wake it first
    host.leave_config(1);
    host.release_strobe();
    wait_for(0, 1'b0, n);
    check1("disch_off", 1'b1, dis_en);
    wait_for(0, 1'b1, n);
    wait_for(0, 1'b0, n);
    check_rng("on_len", 512, 513, n);
    wait_for(0, 1'b1, n);
    check_rng("off_len", WAKE + WAKE / 2, WAKE + WAKE / 2 + 2, n);
    cyc(200);
    id_match = 1'b1;
    cyc(1);
    id_match = 1'b0;
    cyc(400);
    check1("hold", 1'b1, rx_on);
    frame_done = 1'b1;
    cyc(1);
    frame_done = 1'b0;
    wait_for(0, 1'b0, n);
    check_rng("hold_exit", 0, 4, n);
    host.strobe(2);
    cyc(100);
    check1("held_off", 1'b0, rx_on);
    host.strobe(1);
    cyc(5);
    check1("forced_on", 1'b1, rx_on);
    check1("disch_forced", 1'b0, dis_en);
    host.release_strobe();
    $display("test duty done");
  endtask

  task automatic t_level();
    host.strobe(1);
    // Let the forced on state settle so the meter sees no brief off glitch
    cyc(6);
    cfg.strobe_osc_enable = 1'b0;
    lo_code = 4'h5;
    hi_code = 4'ha;
    cfg.level_sample_mode = 1'b1;
    cfg.level_meter_enable = 1'b1;
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    check_rng("clear_len", 7, 7, n);
    check1("power", 1'b1, lvl_pwr);
    check1("out_oe", 1'b1, lvl_oe);
    host.drive(1'b1, 1'b0);
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    check_rng("conv_len", 16, 16, n);
    cyc(40);
    check1("track", 1'b1, track);
    check("status", 8'ha5, status);
    host.drive(1'b0, 1'b0);
    cyc(5);
    lo_code = 4'h3;
    hi_code = 4'hc;
    cyc(70);
    check1("track_off", 1'b0, track);
    check("frozen", 8'ha5, status);
    cfg.level_sample_mode = 1'b0;
    host.drive(1'b1, 1'b0);
    cyc(90);
    check("cont", 8'hc3, status);
    host.drive(1'b0, 1'b0);
    lo_code = 4'h1;
    hi_code = 4'h7;
    cyc(70);
    check("cont_free", 8'h71, status);
    cfg.level_meter_enable = 1'b0;
    cyc(4);
    check1("power_off", 1'b0, lvl_pwr);
    check1("oe_off", 1'b0, lvl_oe);
    $display("test level done");
  endtask

  task automatic t_tx();
    host.to_config();
    cfg.tx_mode = 1'b1;
    pll = 1'b1;
    host.leave_config(1);
    for (int i = 0; i < 4; i++) begin
      cfg.keying_select = i[1];
      host.drive(1'b0, i[0]);
      cyc(5);
      check1("pa", i[1] | i[0], pa_en);
      check1("carrier", i[1] & i[0], car_sel);
    end
    check1("tx_rx_off", 1'b0, rx_on);
    pll = 1'b0;
    cyc(5);
    check1("pa_unlock", 1'b0, pa_en);
    pll = 1'b1;
    $display("test transmit done");
  endtask

  task automatic t_lvd();
    host.to_config();
    cfg.tx_mode = 1'b0;
    cfg.low_voltage_detect_enable = 1'b1;
    host.leave_config(2);
    check1("lvd", 1'b1, lvd);
    check1("standby_plain", 1'b0, standby);
    host.strobe(1);
    cyc(6);
    check1("lvd_kept", 1'b1, lvd);
    check1("rx_stays_off", 1'b0, rx_on);
    $display("test detector done");
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    xtal = 1'b0;
    pll = 1'b0;
    id_match = 1'b0;
    frame_done = 1'b0;
    cfg = '0;
    lo_code = 4'h0;
    hi_code = 4'h0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cyc(4);
    t_standby();
    t_settle();
    t_duty();
    t_level();
    t_tx();
    t_lvd();
    summarize();
  end
endmodule
